// *** hw/address_generation_unit.sv ***
// address generation unit: circular correction, bit-reversed writes
// and program space address construction
// assumes a decoder on the same clock that issues one request a cycle
// How it works
// R1 - x circular correction on selected pointer when enabled
// R2 - y circular correction on selected pointer when enabled
// R3 - select value fifteen turns circular correction off
// R4 - compare past upper or lower limit, overshoot wraps
// R5 - write back only for pre or post modify
// R6 - any working register except register fifteen may be selected
// R7 - reversal only in x unit for writes
// R8 - reversal needs select, enable and increment mode
// R9 - pointer and modifier both taken bit reversed, sum mirrored back
// R10 - pivot scaled to bytes, address bit zero clear
// R11 - byte access or other mode gives normal address
// R12 - reversal adds pivot, ignores mode offset
// R13 - reversal beats circular in x write unit
// R14 - no reversed pointer read right after setup write
// R15 - reversed buffer start aligned to its size
// R16 - sixteen entry sequence mirrors four index bits
// R17 - table address is page over full address
// R18 - page top bit picks configuration space
// R19 - window address is page over low fifteen bits
// R20 - window is read only, low word only
// R21 - table access reaches every byte of word
// R22 - limits from four start and end registers
// R23 - y circular addresses keep bit zero clear
// R24 - wrap by subtracting or adding buffer length
`timescale 1ns/10ps
`default_nettype none

module address_generation_unit
    import agu_pkg::*;
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  sys_rst_i,
    // register port
    input  wire logic [REG_ADDR_W-1:0] reg_addr_i,
    input  wire logic [DATA_W-1:0]     reg_wdata_i,
    input  wire logic                  reg_we_i,
    input  wire logic                  reg_re_i,
    output logic      [DATA_W-1:0]     reg_rdata_o,
    // data address request and answer
    input  wire logic                  addr_valid_i,
    input  wire addr_req_t             addr_req_i,
    output logic                       addr_valid_o,
    output addr_resp_t                 addr_resp_o,
    // program space request and answer
    input  wire logic                  prog_valid_i,
    input  wire prog_req_t             prog_req_i,
    output logic                       prog_valid_o,
    output prog_resp_t                 prog_resp_o
);

    // ==================================================================
    // registers
    logic [15:0] control;      // modulo_bitrev_control
    logic [15:0] bitrev_setup; // reversal enable and pivot
    logic [7:0]  table_page;   // table_page_select
    logic [7:0]  window_page;  // window_page_select
    logic [15:0] x_start;      // x_buffer_start
    logic [15:0] x_end;        // x_buffer_end
    logic [15:0] y_start;      // y_buffer_start
    logic [15:0] y_end;        // y_buffer_end
    logic        window_en;    // program_window enable
    logic [15:0] last_ea;      // last generated data address

    // ==================================================================
    // helper functions
    // mirror sixteen bits end for end
    function automatic logic [15:0] rev16(input logic [15:0] v);
        return {<<{v}};
    endfunction
    // wrap an address back into its circular buffer
    function automatic logic [15:0] circ_fix(input logic [15:0] a,
                                             input logic [15:0] st,
                                             input logic [15:0] en,
                                             input logic        dec);
        logic [15:0] len;
        len = en - st + ONE_WORD; // R22
        circ_fix = a;
        if (!dec && (a > en)) begin
            circ_fix = a - len; // R4 R24
        end else if (dec && (a < st)) begin
            circ_fix = a + len; // R4 R24
        end
    endfunction

    // ==================================================================
    // register writes, one process per register group
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            control      <= CONTROL_RST;
            bitrev_setup <= WORD_RST;
        end else if (reg_we_i && (reg_addr_i == IDX_CONTROL)) begin
            control <= reg_wdata_i;
        end else if (reg_we_i && (reg_addr_i == IDX_BITREV)) begin
            bitrev_setup <= reg_wdata_i;
        end
    end
    // page registers and window enable
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            table_page  <= PAGE_RST;
            window_page <= PAGE_RST;
            window_en   <= 1'b0;
        end else if (reg_we_i && (reg_addr_i == IDX_TABLE_PAGE)) begin
            table_page <= reg_wdata_i[7:0];
        end else if (reg_we_i && (reg_addr_i == IDX_WINDOW_PAGE)) begin
            window_page <= reg_wdata_i[7:0];
        end else if (reg_we_i && (reg_addr_i == IDX_WINDOW_CTRL)) begin
            window_en <= reg_wdata_i[WINEN_BIT];
        end
    end
    // buffer limit registers
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            x_start <= WORD_RST;
            x_end   <= WORD_RST;
            y_start <= WORD_RST;
            y_end   <= WORD_RST;
        end else if (reg_we_i) begin
            case (reg_addr_i)
                IDX_X_START: x_start <= reg_wdata_i; // R22
                IDX_X_END:   x_end   <= reg_wdata_i;
                IDX_Y_START: y_start <= reg_wdata_i;
                IDX_Y_END:   y_end   <= reg_wdata_i;
                default:     ; // other indices are not limits
            endcase
        end
    end
    // read data one cycle after the strobe, unmapped reads give zero
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= WORD_RST;
        end else if (reg_re_i) begin
            case (reg_addr_i)
                IDX_CONTROL:     reg_rdata_o <= control;
                IDX_BITREV:      reg_rdata_o <= bitrev_setup;
                IDX_TABLE_PAGE:  reg_rdata_o <= {8'h00, table_page};
                IDX_WINDOW_PAGE: reg_rdata_o <= {8'h00, window_page};
                IDX_X_START:     reg_rdata_o <= x_start;
                IDX_X_END:       reg_rdata_o <= x_end;
                IDX_Y_START:     reg_rdata_o <= y_start;
                IDX_Y_END:       reg_rdata_o <= y_end;
                IDX_WINDOW_CTRL: reg_rdata_o <= {15'h0000, window_en};
                IDX_LAST_EA:     reg_rdata_o <= last_ea;
                default:         reg_rdata_o <= WORD_RST;
            endcase
        end else begin
            reg_rdata_o <= WORD_RST;
        end
    end

    // ==================================================================
    // control field decode
    wire logic [3:0]  x_sel      = control[XSEL_LSB +: 4];  // x select
    wire logic [3:0]  y_sel      = control[YSEL_LSB +: 4];  // y select
    wire logic [3:0]  rev_sel    = control[BRSEL_LSB +: 4]; // reversal select
    wire logic        x_en       = control[XEN_BIT];        // x enable
    wire logic        y_en       = control[YEN_BIT];        // y enable
    wire logic        rev_en     = bitrev_setup[REVEN_BIT]; // reversal enable
    wire logic [15:0] pivot_byte = {bitrev_setup[14:0], 1'b0}; // R10

    // ==================================================================
    // data address computation
    logic        next_rev;     // reversal in force for this request
    logic        next_circ;    // circular correction in force
    logic        is_inc;       // mode is pre or post increment
    logic        is_dec;       // address moves downward
    logic        is_pre;       // modified address is the access address
    logic        is_wb;        // pointer is written back
    logic [15:0] moved;        // pointer after its normal step
    logic [15:0] fixed;        // moved address after correction
    logic [15:0] rev_sum;      // reverse carry sum of pointer and pivot
    addr_resp_t  next_resp;    // answer presented next cycle

    always_comb begin
        is_inc = (addr_req_i.mode == MODE_POST_INC) ||
                 (addr_req_i.mode == MODE_PRE_INC);
        is_pre = (addr_req_i.mode == MODE_PRE_INC) ||
                 (addr_req_i.mode == MODE_PRE_DEC) ||
                 (addr_req_i.mode == MODE_OFFSET);
        is_wb  = (addr_req_i.mode != MODE_INDIRECT) &&
                 (addr_req_i.mode != MODE_OFFSET); // R5
        is_dec = (addr_req_i.mode == MODE_POST_DEC) ||
                 (addr_req_i.mode == MODE_PRE_DEC) ||
                 ((addr_req_i.mode == MODE_OFFSET) &&
                  addr_req_i.offset[15]);
        // normal step, subtract for decrement modes
        if (addr_req_i.mode == MODE_INDIRECT) begin
            moved = addr_req_i.ptr;
        end else if (is_dec && (addr_req_i.mode != MODE_OFFSET)) begin
            moved = addr_req_i.ptr - addr_req_i.offset;
        end else begin
            moved = addr_req_i.ptr + addr_req_i.offset;
        end
        // reversal: x writes of words in increment modes only
        next_rev = (addr_req_i.unit == UNIT_X_WRITE) && // R7
                   (rev_sel != SEL_NONE) && rev_en && // R8
                   (addr_req_i.wreg == rev_sel) &&
                   is_inc && !addr_req_i.byte_acc; // R11
        // pointer and pivot are both mirrored, added, and the sum mirrored back
        rev_sum = rev16(rev16(addr_req_i.ptr) + rev16(pivot_byte)); // R9 R16
        rev_sum = rev_sum & LSB_CLEAR; // R10
        // circular correction per unit, any register except fifteen may be chosen
        case (addr_req_i.unit)
            UNIT_X_READ: begin
                next_circ = (x_sel != SEL_NONE) && x_en && // R1 R3
                            (addr_req_i.wreg == x_sel); // R6
                fixed = circ_fix(moved, x_start, x_end, is_dec);
            end
            UNIT_X_WRITE: begin
                next_circ = (x_sel != SEL_NONE) && x_en &&
                            (addr_req_i.wreg == x_sel) &&
                            !next_rev; // R13
                fixed = circ_fix(moved, x_start, x_end, is_dec);
            end
            UNIT_Y: begin
                next_circ = (y_sel != SEL_NONE) && y_en && // R2 R3
                            (addr_req_i.wreg == y_sel);
                fixed = circ_fix(moved, y_start, y_end, is_dec) &
                        LSB_CLEAR; // R23
            end
            default: begin
                next_circ = 1'b0;
                fixed     = moved;
            end
        endcase
        if (!next_circ) fixed = moved;
        if (next_rev) fixed = rev_sum; // R12
        // access address and write back
        next_resp.ea       = is_pre ? fixed : addr_req_i.ptr;
        next_resp.wb_en    = is_wb;
        next_resp.wb_reg   = addr_req_i.wreg;
        next_resp.wb_val   = is_wb ? fixed : addr_req_i.ptr; // R5
        next_resp.circular = next_circ;
        next_resp.reversed = next_rev;
    end
    // data address answer register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            addr_valid_o <= 1'b0;
            addr_resp_o  <= '0;
            last_ea      <= WORD_RST;
        end else begin
            addr_valid_o <= addr_valid_i;
            if (addr_valid_i) begin
                addr_resp_o <= next_resp;
                last_ea     <= next_resp.ea;
            end
        end
    end

    // ==================================================================
    // program space address construction
    prog_resp_t next_prog; // program answer presented next cycle
    always_comb begin
        next_prog = '0;
        if (prog_req_i.table_acc) begin
            next_prog.addr         = {table_page, prog_req_i.ea}; // R17 R21
            next_prog.hit          = 1'b1;
            next_prog.config_space = table_page[CONFIG_BIT]; // R18
        end else if (prog_req_i.ea[EA_MSB] && window_en) begin
            next_prog.addr          = {1'b0, window_page,
                                       prog_req_i.ea[14:0]}; // R19
            next_prog.hit           = !prog_req_i.write; // R20
            next_prog.low_word_only = 1'b1; // R20
            next_prog.refused       = prog_req_i.write; // R20
        end
    end
    // program answer register
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            prog_valid_o <= 1'b0;
            prog_resp_o  <= '0;
        end else begin
            prog_valid_o <= prog_valid_i;
            if (prog_valid_i) begin
                prog_resp_o <= next_prog;
            end
        end
    end

    // ==================================================================
    // assertions
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    property p_x_circ_on;
        addr_valid_i && (addr_req_i.unit == UNIT_X_READ) && x_en &&
        (x_sel != SEL_NONE) && (addr_req_i.wreg == x_sel)
        |=> addr_valid_o && addr_resp_o.circular;
    endproperty
    a_x_circ_on: assert property (p_x_circ_on) // R1
        else $error("x circular correction missing");
    property p_y_circ_on;
        addr_valid_i && (addr_req_i.unit == UNIT_Y) && y_en &&
        (y_sel != SEL_NONE) && (addr_req_i.wreg == y_sel)
        |=> addr_resp_o.circular && !addr_resp_o.ea[0];
    endproperty
    a_y_circ_on: assert property (p_y_circ_on) // R2
        else $error("y circular correction missing");
    property p_sel_none;
        addr_valid_i && (addr_req_i.unit != UNIT_Y) && (x_sel == SEL_NONE)
        |=> !addr_resp_o.circular;
    endproperty
    a_sel_none: assert property (p_sel_none) // R3
        else $error("circular correction with select fifteen");
    property p_offset_no_wb;
        addr_valid_i && (addr_req_i.mode == MODE_OFFSET)
        |=> !addr_resp_o.wb_en &&
            (addr_resp_o.wb_val == $past(addr_req_i.ptr));
    endproperty
    a_offset_no_wb: assert property (p_offset_no_wb) // R5
        else $error("pointer changed in offset mode");
    property p_rev_write_only;
        addr_valid_i && ((addr_req_i.unit != UNIT_X_WRITE) ||
                         addr_req_i.byte_acc)
        |=> !addr_resp_o.reversed;
    endproperty
    a_rev_write_only: assert property (p_rev_write_only) // R7
        else $error("reversal outside word x writes");
    property p_rev_lsb;
        addr_valid_o && addr_resp_o.reversed
        |-> !addr_resp_o.wb_val[0] && !addr_resp_o.circular;
    endproperty
    a_rev_lsb: assert property (p_rev_lsb) // R13
        else $error("reversed address odd or also circular");
    property p_x_wrap;
        addr_valid_i && (addr_req_i.unit == UNIT_X_READ) && x_en &&
        (x_sel != SEL_NONE) && (addr_req_i.wreg == x_sel) &&
        (addr_req_i.mode == MODE_POST_INC) && (x_start <= x_end) &&
        (16'(addr_req_i.ptr + addr_req_i.offset) > x_end)
        |=> addr_resp_o.wb_val == 16'($past(addr_req_i.ptr) +
            $past(addr_req_i.offset) - ($past(x_end) - $past(x_start)
            + ONE_WORD));
    endproperty
    a_x_wrap: assert property (p_x_wrap) // R24
        else $error("incrementing wrap wrong");
    property p_table_addr;
        prog_valid_i && prog_req_i.table_acc
        |=> prog_resp_o.addr == {$past(table_page), $past(prog_req_i.ea)};
    endproperty
    a_table_addr: assert property (p_table_addr) // R17
        else $error("table address wrong");
    property p_window_read_only;
        prog_valid_i && !prog_req_i.table_acc && window_en &&
        prog_req_i.ea[EA_MSB] && prog_req_i.write
        |=> prog_resp_o.refused && !prog_resp_o.hit && !prog_resp_o.addr[23];
    endproperty
    a_window_read_only: assert property (p_window_read_only) // R20
        else $error("window write not refused");
    c_reversed: cover property (addr_valid_o && addr_resp_o.reversed);
    c_circular: cover property (addr_valid_o && addr_resp_o.circular &&
                                addr_resp_o.wb_en);
    c_window:   cover property (prog_valid_o && prog_resp_o.low_word_only &&
                                prog_resp_o.hit);
    c_config:   cover property (prog_valid_o && prog_resp_o.config_space);

endmodule

`default_nettype wire

// *** pkg/agu_pkg.sv ***
// constants, register map and carrier types of the address generator
// assumes a 16-bit core data path and a 24-bit program address space
package agu_pkg;

    // ==================================================================
    // register map (word indices on the register port)
    localparam int unsigned REG_ADDR_W      = 4;
    localparam int unsigned DATA_W          = 16;
    localparam logic [3:0]  IDX_CONTROL     = 4'h0;
    localparam logic [3:0]  IDX_BITREV      = 4'h1;
    localparam logic [3:0]  IDX_TABLE_PAGE  = 4'h2;
    localparam logic [3:0]  IDX_WINDOW_PAGE = 4'h3;
    localparam logic [3:0]  IDX_X_START     = 4'h4;
    localparam logic [3:0]  IDX_X_END       = 4'h5;
    localparam logic [3:0]  IDX_Y_START     = 4'h6;
    localparam logic [3:0]  IDX_Y_END       = 4'h7;
    localparam logic [3:0]  IDX_WINDOW_CTRL = 4'h8;
    localparam logic [3:0]  IDX_LAST_EA     = 4'h9;

    // ==================================================================
    // field positions
    localparam int unsigned XEN_BIT    = 15;
    localparam int unsigned YEN_BIT    = 14;
    localparam int unsigned XSEL_LSB   = 0;
    localparam int unsigned YSEL_LSB   = 4;
    localparam int unsigned BRSEL_LSB  = 8;
    localparam int unsigned REVEN_BIT  = 15;
    localparam int unsigned CONFIG_BIT = 7;
    localparam int unsigned WINEN_BIT  = 0;
    localparam int unsigned EA_MSB     = 15;

    // ==================================================================
    // codes and reset values
    localparam logic [3:0]  SEL_NONE      = 4'hf;
    localparam logic [15:0] CONTROL_RST   = 16'h0fff;
    localparam logic [15:0] WORD_RST      = 16'h0000;
    localparam logic [7:0]  PAGE_RST      = 8'h00;
    localparam logic [15:0] ONE_WORD      = 16'h0001;
    localparam logic [15:0] LSB_CLEAR     = 16'hfffe;

    // address unit that issues a request
    typedef enum logic [1:0] {
        UNIT_X_READ  = 2'b00,
        UNIT_X_WRITE = 2'b01,
        UNIT_Y       = 2'b10
    } unit_t;

    // indirect addressing mode of the access
    typedef enum logic [2:0] {
        MODE_INDIRECT = 3'b000,
        MODE_POST_INC = 3'b001,
        MODE_POST_DEC = 3'b010,
        MODE_PRE_INC  = 3'b011,
        MODE_PRE_DEC  = 3'b100,
        MODE_OFFSET   = 3'b101
    } mode_t;

    // data address request from the decoder
    typedef struct packed {
        unit_t       unit;
        logic [3:0]  wreg;
        mode_t       mode;
        logic [15:0] ptr;
        logic [15:0] offset;
        logic        byte_acc;
    } addr_req_t;

    // data address answer
    typedef struct packed {
        logic [15:0] ea;
        logic        wb_en;
        logic [3:0]  wb_reg;
        logic [15:0] wb_val;
        logic        circular;
        logic        reversed;
    } addr_resp_t;

    // program space request
    typedef struct packed {
        logic        table_acc;
        logic        write;
        logic [15:0] ea;
    } prog_req_t;

    // program space answer
    typedef struct packed {
        logic [23:0] addr;
        logic        hit;
        logic        config_space;
        logic        low_word_only;
        logic        refused;
    } prog_resp_t;

endpackage

// *** verification/program_memory_model.sv ***
// program memory that answers the generator's program address port
// assumes one answer per prog_valid pulse, read in that same cycle
`timescale 1ns/10ps
`default_nettype none

module program_memory_model
    import agu_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // program address from the generator
    input  wire logic        prog_valid_i,
    input  wire prog_resp_t  prog_resp_i,
    // word handed back to the core
    output logic      [23:0] rdata_o
);
    logic        toggle = 1'b0; // idle pattern, never a stale word
    logic [23:0] word;          // stored word at the address

    // ==================================================================
    // released bus flips every cycle
    always @(posedge clk_i) begin
        toggle <= ~toggle;
    end

    // content is a fixed scramble of the address
    assign word = {prog_resp_i.addr[23:16] ^ 8'ha5,
                   prog_resp_i.addr[15:0] ^ 16'h3c3c};

    // drive only for a hit, low word alone through the window
    always_comb begin
        if (!(prog_valid_i && prog_resp_i.hit)) begin
            rdata_o = {24{toggle}};
        end else if (prog_resp_i.low_word_only) begin
            rdata_o = {8'h00, word[15:0]};
        end else begin
            rdata_o = word;
        end
    end
endmodule

`default_nettype wire

// *** verification/address_generation_unit_tb.sv ***
// self-checking bench for the address generation unit
// assumes the package register map and a 250 MHz core clock
`timescale 1ns/10ps
`default_nettype none

module address_generation_unit_tb
    import agu_pkg::*;
;
    localparam unit_t XR = UNIT_X_READ;
    localparam unit_t XW = UNIT_X_WRITE;
    localparam unit_t YU = UNIT_Y;
    localparam mode_t PI = MODE_POST_INC;
    localparam mode_t PD = MODE_POST_DEC;
    logic        clk_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic        reg_we_i = 1'b0;
    logic        reg_re_i = 1'b0;
    logic [15:0] reg_rdata_o;
    logic        addr_valid_i = 1'b0;
    addr_req_t   addr_req_i = '0;
    logic        addr_valid_o;
    addr_resp_t  addr_resp_o;
    logic        prog_valid_i = 1'b0;
    prog_req_t   prog_req_i = '0;
    logic        prog_valid_o;
    prog_resp_t  prog_resp_o;
    logic [23:0] mem_rdata;
    int          bad_count = 0;
    int          num_checks = 0;

    address_generation_unit address_generation_unit_i (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
        .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
        .addr_valid_i(addr_valid_i), .addr_req_i(addr_req_i),
        .addr_valid_o(addr_valid_o), .addr_resp_o(addr_resp_o),
        .prog_valid_i(prog_valid_i), .prog_req_i(prog_req_i),
        .prog_valid_o(prog_valid_o), .prog_resp_o(prog_resp_o));
    program_memory_model program_memory_model_i (.clk_i(clk_i),
        .prog_valid_i(prog_valid_o), .prog_resp_i(prog_resp_o),
        .rdata_o(mem_rdata));

    // ==================================================================
    // helpers
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_i);
        reg_we_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_i);
        reg_re_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_re_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    // f holds expected {write back, circular, reversed}
    task automatic dreq(input unit_t u, input logic [3:0] w, input mode_t m,
        input logic [15:0] p, o, input logic b, input logic [15:0] ea, v,
        input logic [2:0] f);
        @(posedge clk_i);
        addr_valid_i <= 1'b1;
        addr_req_i <= '{u, w, m, p, o, b};
        @(posedge clk_i);
        addr_valid_i <= 1'b0;
        #1 chk({addr_valid_o, addr_resp_o.ea, addr_resp_o.wb_reg,
            addr_resp_o.wb_en, addr_resp_o.circular, addr_resp_o.reversed},
            {1'b1, ea, w, f});
        if (f[2]) chk(addr_resp_o.wb_val, v);
    endtask
    // f holds expected {hit, configuration, low word, refused}
    task automatic preq(input logic t, w, input logic [15:0] e,
        input logic [3:0] f, input logic [23:0] a, d);
        @(posedge clk_i);
        prog_valid_i <= 1'b1;
        prog_req_i <= '{t, w, e};
        @(posedge clk_i);
        prog_valid_i <= 1'b0;
        #1 chk({prog_valid_o, prog_resp_o.hit, prog_resp_o.refused},
            {1'b1, f[3], f[0]});
        if (f[3]) begin
            chk({prog_resp_o.config_space, prog_resp_o.low_word_only,
                prog_resp_o.addr}, {f[2:1], a});
            chk(mem_rdata, d);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==================================================================
    // scenarios
    task automatic t_regs();
        logic [15:0] d;
        rd(IDX_CONTROL, d);
        chk(d, CONTROL_RST);
        wr(IDX_LAST_EA, 16'hffff);
        wr(4'ha, 16'hffff);
        for (int i = 1; i < 11; i++) begin
            rd(i[3:0], d);
            chk(d, 16'h0000);
        end
    endtask
    task automatic t_xcirc();
        logic [15:0] d;
        wr(IDX_X_START, 16'h1000);
        wr(IDX_X_END, 16'h100f);
        wr(IDX_CONTROL, 16'h8ff3);
        dreq(XR, 4'h3, PI, 16'h100e, 16'h4, 1'b0, 16'h100e, 16'h1002, 3'h6);
        dreq(XR, 4'h4, PI, 16'h100e, 16'h4, 1'b0, 16'h100e, 16'h1012, 3'h4);
        dreq(XW, 4'h3, MODE_PRE_DEC, 16'h1000, 16'h2, 1'b0, 16'h100e,
            16'h100e, 3'h6);
        dreq(XR, 4'h3, MODE_INDIRECT, 16'h100e, 16'h4, 1'b0, 16'h100e, 16'h0,
            3'h2);
        dreq(XR, 4'h3, MODE_OFFSET, 16'h100e, 16'h4, 1'b0, 16'h1002, 16'h0,
            3'h2);
        rd(IDX_LAST_EA, d);
        chk(d, 16'h1002);
        wr(IDX_CONTROL, 16'h8ffc);
        dreq(XR, 4'hc, PI, 16'h100c, 16'h8, 1'b0, 16'h100c, 16'h1004, 3'h6);
        wr(IDX_CONTROL, 16'h8fff);
        dreq(XR, 4'hf, PI, 16'h100e, 16'h4, 1'b0, 16'h100e, 16'h1012, 3'h4);
    endtask
    task automatic t_ycirc();
        wr(IDX_Y_START, 16'h2000);
        wr(IDX_Y_END, 16'h201f);
        wr(IDX_CONTROL, 16'h4f5f);
        dreq(YU, 4'h5, PI, 16'h201e, 16'h2, 1'b0, 16'h201e, 16'h2000, 3'h6);
        dreq(YU, 4'h5, MODE_PRE_DEC, 16'h2000, 16'h3, 1'b0, 16'h201c,
            16'h201c, 3'h6);
        dreq(XR, 4'h5, PI, 16'h201e, 16'h2, 1'b0, 16'h201e, 16'h2020, 3'h4);
    endtask
    task automatic t_rev();
        logic [15:0] seq [3] = '{16'h0410, 16'h0408, 16'h0418};
        logic [15:0] p;
        wr(IDX_CONTROL, 16'h02ff);
        wr(IDX_BITREV, 16'h8008);
        p = 16'h0400;
        foreach (seq[i]) begin
            dreq(XW, 4'h2, PI, p, 16'h2, 1'b0, p, seq[i], 3'h5);
            p = seq[i];
        end
        dreq(XW, 4'h2, MODE_PRE_INC, p, 16'h2, 1'b0, 16'h0404, 16'h0404,
            3'h5);
        dreq(XW, 4'h2, PI, 16'h0400, 16'h1, 1'b1, 16'h0400, 16'h0401, 3'h4);
        dreq(XW, 4'h2, PD, 16'h0400, 16'h2, 1'b0, 16'h0400, 16'h03fe, 3'h4);
        dreq(XR, 4'h2, PI, 16'h0400, 16'h2, 1'b0, 16'h0400, 16'h0402, 3'h4);
        dreq(XW, 4'h3, PI, 16'h0400, 16'h2, 1'b0, 16'h0400, 16'h0402, 3'h4);
        wr(IDX_X_START, 16'h0400);
        wr(IDX_X_END, 16'h040f);
        wr(IDX_CONTROL, 16'h82f2);
        dreq(XW, 4'h2, PI, 16'h0408, 16'h2, 1'b0, 16'h0408, 16'h0418, 3'h5);
        dreq(XR, 4'h2, PI, 16'h040e, 16'h2, 1'b0, 16'h040e, 16'h0400, 3'h6);
    endtask
    task automatic t_prog();
        wr(IDX_TABLE_PAGE, 16'h0085);
        wr(IDX_WINDOW_PAGE, 16'h0012);
        wr(IDX_WINDOW_CTRL, 16'h0001);
        preq(1'b1, 1'b0, 16'h1234, 4'hc, 24'h851234, 24'h202e08);
        wr(IDX_TABLE_PAGE, 16'h0005);
        preq(1'b1, 1'b1, 16'h1234, 4'h8, 24'h051234, 24'ha02e08);
        preq(1'b0, 1'b0, 16'h9234, 4'ha, 24'h091234, 24'h002e08);
        preq(1'b0, 1'b1, 16'h9234, 4'h1, 24'h0, 24'h0);
        preq(1'b0, 1'b0, 16'h1234, 4'h0, 24'h0, 24'h0);
        wr(IDX_WINDOW_CTRL, 16'h0000);
        preq(1'b0, 1'b0, 16'h9234, 4'h0, 24'h0, 24'h0);
    endtask

    // ==================================================================
    // clock, watchdog and main sequence
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        t_regs();
        t_xcirc();
        t_ycirc();
        t_rev();
        t_prog();
        final_report();
    end
endmodule

`default_nettype wire
